// ---- dv/tb_top.sv ----
// Purpose: Self-checking bench for the regulator five/six/seven control bank
// Assumes: Turn-on step shortened to 4 cycles; power-good is driven directly by the bench
// Notes: Each scenario is its own task and judges its own results before returning

`timescale 1ns/1ps

module tb_top;
    localparam int STEP = 4;

    logic clk_i;
    logic resetn_i;
    logic [7:0] addr_i;
    logic [7:0] wdata_i;
    logic wr_i;
    logic rd_i;
    logic [7:0] rdata_o;
    logic [2:0] pgood_i;
    logic [2:0] ldo_run_o;
    logic [2:0] discharge_o;
    logic [2:0] low_quiescent_mode_o;
    logic [2:0][5:0] voltage_code_o;
    logic interrupt_out_n_o;
    logic interrupt_oe_o;
    int miscompares;
    int checks;
    int cycles;
    logic [7:0] rv;

    // Short step so that the longest delay code still runs in a few dozen cycles
    ldoctl_regs #(.TURN_ON_STEP_CYCLES(STEP)) dut (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .addr_i(addr_i),
        .wdata_i(wdata_i),
        .wr_i(wr_i),
        .rd_i(rd_i),
        .rdata_o(rdata_o),
        .pgood_i(pgood_i),
        .ldo_run_o(ldo_run_o),
        .discharge_o(discharge_o),
        .low_quiescent_mode_o(low_quiescent_mode_o),
        .voltage_code_o(voltage_code_o),
        .interrupt_out_n_o(interrupt_out_n_o),
        .interrupt_oe_o(interrupt_oe_o)
    );

    // Free-running 40 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic summarize();
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : summarize

    // Single-cycle write; returns just after the edge that takes it
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr_reg

    // Read data is only valid in the cycle after the strobe, so it is sampled there
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask : rd_reg

    task automatic test_reset();
        for (int i = 0; i < 3; i++) begin
            rd_reg(ldoctl_pkg::VSEL_ADDR[i], rv);
            check(rv, 8'h00);
            rd_reg(ldoctl_pkg::CTL_ADDR[i], rv);
            check(rv, 8'h00);
        end
        rd_reg(8'h56, rv);
        check(rv, 8'h00);
        check(8'(ldo_run_o), 8'h00);
        check(8'(discharge_o), 8'h00);
        check(8'({interrupt_out_n_o, interrupt_oe_o}), 8'h02);
        $display("test_reset finished");
    endtask : test_reset

    task automatic test_vsel();
        logic [7:0] d;
        for (int i = 0; i < 3; i++) begin
            d = 8'hff ^ 8'(i);
            wr_reg(ldoctl_pkg::VSEL_ADDR[i], d);
            #1 check(8'(voltage_code_o[i]), d & 8'h3f);
            wr_reg(8'h56, 8'haa);
            rd_reg(ldoctl_pkg::VSEL_ADDR[i], rv);
            check(rv, d & 8'h3f);
            @(posedge clk_i);
            #1 check(rdata_o, 8'h00);
        end
        // Write then read with no idle cycle between the strobes
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= ldoctl_pkg::VSEL_ADDR[0];
        wdata_i <= 8'h15;
        @(posedge clk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 check(rdata_o, 8'h15);
        $display("test_vsel finished");
    endtask : test_vsel

    task automatic test_ctrl();
        logic [2:0] c;
        for (int i = 0; i < 3; i++) begin
            c = (i == 1) ? 3'h7 : 3'(i * 3);
            @(posedge clk_i);
            pgood_i[i] <= 1'b0;
            wr_reg(ldoctl_pkg::CTL_ADDR[i], 8'h41 | {3'h0, c, 2'h0});
            @(posedge clk_i);
            #1 check(8'(discharge_o[i]), 8'h01);
            check(8'(ldo_run_o[i]), 8'h00);
            rd_reg(ldoctl_pkg::CTL_ADDR[i], rv);
            check(rv, 8'h40 | {3'h0, c, 2'h0});
            @(posedge clk_i);
            pgood_i[i] <= 1'b1;
            rd_reg(ldoctl_pkg::CTL_ADDR[i], rv);
            check(rv, 8'h41 | {3'h0, c, 2'h0});
            wr_reg(ldoctl_pkg::CTL_ADDR[i], 8'he0 | {3'h0, c, 2'h0});
            #1 check(8'(low_quiescent_mode_o[i]), 8'h01);
            repeat (1 + int'(c) * STEP) @(posedge clk_i);
            #1 check(8'({ldo_run_o[i], discharge_o[i]}), 8'h01);
            @(posedge clk_i);
            #1 check(8'(ldo_run_o[i]), 8'h01);
            @(posedge clk_i);
            #1 check(8'(discharge_o[i]), 8'h00);
            wr_reg(ldoctl_pkg::CTL_ADDR[i], 8'h00);
            #1 check(8'(low_quiescent_mode_o[i]), 8'h00);
            @(posedge clk_i);
            #1 check(8'(ldo_run_o[i]), 8'h00);
        end
        $display("test_ctrl finished");
    endtask : test_ctrl

    task automatic test_fault();
        wr_reg(ldoctl_pkg::CTL_ADDR[0], 8'h82);
        repeat (3) @(posedge clk_i);
        pgood_i[0] <= 1'b0;
        @(posedge clk_i);
        #1 check(8'(interrupt_out_n_o), 8'h01);
        @(posedge clk_i);
        #1 check(8'({interrupt_out_n_o, interrupt_oe_o}), 8'h01);
        rd_reg(ldoctl_pkg::CTL_ADDR[0], rv);
        check(rv, 8'h82);
        repeat (2) @(posedge clk_i);
        #1 check(8'({interrupt_out_n_o, interrupt_oe_o}), 8'h02);
        // Same drop with the fault interrupt disabled must stay silent
        @(posedge clk_i);
        pgood_i[0] <= 1'b1;
        wr_reg(ldoctl_pkg::CTL_ADDR[0], 8'h80);
        repeat (3) @(posedge clk_i);
        pgood_i[0] <= 1'b0;
        repeat (4) @(posedge clk_i);
        #1 check(8'({interrupt_out_n_o, interrupt_oe_o}), 8'h02);
        wr_reg(ldoctl_pkg::CTL_ADDR[0], 8'h00);
        $display("test_fault finished");
    endtask : test_fault

    // Cycle ceiling well above the fewer than two hundred cycles the scenarios need
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            summarize();
        end
    end

    // Reset for three cycles, then the scenarios in turn
    initial begin
        miscompares = 0;
        checks = 0;
        cycles = 0;
        resetn_i = 1'b0;
        addr_i = 8'h00;
        wdata_i = 8'h00;
        wr_i = 1'b0;
        rd_i = 1'b0;
        pgood_i = 3'h0;
        repeat (3) @(posedge clk_i);
        resetn_i <= 1'b1;
        test_reset();
        test_vsel();
        test_ctrl();
        test_fault();
        summarize();
    end
endmodule : tb_top

// ---- hw/ldoctl_fault_latch.sv ----
// Purpose: Sticky power-good loss flag for one regulator
// Assumes: pgood_i is synchronous to clk_i
// Notes: A new fault in the clear cycle keeps the flag set

`timescale 1ns/1ps

module ldoctl_fault_latch (
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Regulator state
    input wire logic running_i,
    input wire logic pgood_i,
    input wire logic irq_enable_i,
    // Software clear
    input wire logic clear_i,
    // Sticky flag
    output logic fault_o
);

    logic pgood_q;
    logic pgood_fall;

    // Only a loss while running counts; a commanded shutdown is not a fault
    assign pgood_fall = running_i && pgood_q && !pgood_i;

    // Previous power-good sample
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            pgood_q <= 1'b0;
        end else begin
            pgood_q <= pgood_i;
        end
    end

    // Set beats clear
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            fault_o <= 1'b0;
        end else if (pgood_fall && irq_enable_i) begin
            fault_o <= 1'b1;
        end else if (clear_i) begin
            fault_o <= 1'b0;
        end
    end

    a_fall_sets_fault: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (pgood_fall && irq_enable_i) |=> fault_o)
        else $error("power-good loss did not set the fault flag");

    a_masked_no_set: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (!fault_o && !irq_enable_i) |=> !fault_o)
        else $error("fault flag set while fault interrupt disabled");

endmodule : ldoctl_fault_latch

// ---- hw/ldoctl_pkg.sv ----
// Purpose: Shared constants, types and decode helpers for the LDO five/six/seven control bank
// Assumes: Byte-wide registers on an 8-bit address space, 40 MHz system clock
// Notes: Reset values are all zero, so every regulator starts disabled

package ldoctl_pkg;

    // Bank geometry
    localparam int NUM_LDO = 3;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int VCODE_W = 6;
    localparam int DELAY_W = 3;

    // Register offsets, index 0 = ldo_five, 1 = ldo_six, 2 = ldo_seven
    localparam logic [ADDR_W-1:0] VSEL_ADDR [0:NUM_LDO-1] = '{8'h54, 8'h60, 8'h64};
    localparam logic [ADDR_W-1:0] CTL_ADDR [0:NUM_LDO-1] = '{8'h55, 8'h61, 8'h65};

    // Control register field positions
    localparam int CTL_ENABLE_BIT = 7;
    localparam int CTL_DISCHARGE_BIT = 6;
    localparam int CTL_LOW_QUIESCENT_BIT = 5;
    localparam int CTL_DELAY_MSB = 4;
    localparam int CTL_DELAY_LSB = 2;
    localparam int CTL_FAULT_IE_BIT = 1;
    localparam int CTL_PGOOD_BIT = 0;

    // Voltage select field and its reserved top bits
    localparam int VSEL_CODE_MSB = 5;
    localparam logic [1:0] VSEL_RESERVED = 2'h0;

    // Reset values
    localparam logic [VCODE_W-1:0] VCODE_RESET = 6'h00;
    localparam logic [DELAY_W-1:0] DELAY_RESET = 3'h0;
    localparam logic [DATA_W-1:0] RDATA_IDLE = 8'h00;

    // Turn-on delay timing: one code step is a fixed time
    localparam int CLK_FREQ_HZ = 40_000_000;
    localparam int DELAY_STEP_US = 64;
    localparam int DELAY_STEP_CYCLES = (DELAY_STEP_US * (CLK_FREQ_HZ / 1_000_000));
    localparam int DELAY_CNT_W = 16;

    // Turn-on sequencer states, Gray coded along off, wait, on
    typedef enum logic [1:0] {
        LDOCTL_OFF = 2'b00,
        LDOCTL_WAIT = 2'b01,
        LDOCTL_ON = 2'b11
    } ldoctl_state_e;

    // Looks an address up in an offset table: {hit, index}
    function automatic logic [2:0] addr_lookup(input logic [ADDR_W-1:0] addr,
                                               input logic [ADDR_W-1:0] tbl [0:NUM_LDO-1]);
        logic [2:0] res;
        res = 3'h0;
        for (int k = 0; k < NUM_LDO; k++) begin
            if (addr == tbl[k]) begin
                res = {1'b1, 2'(k)};
            end
        end
        return res;
    endfunction : addr_lookup

endpackage : ldoctl_pkg

// ---- hw/ldoctl_regs.sv ----
// Purpose: Control and status register bank for low-dropout regulators five, six and seven
// Assumes: Single-cycle write and read strobes, read data valid in the following cycle only
// Notes: Reading a control register clears that regulator's sticky fault flag
//
// The plain strobed port was decided locally.

`timescale 1ns/1ps

module ldoctl_regs #(
    parameter int TURN_ON_STEP_CYCLES = ldoctl_pkg::DELAY_STEP_CYCLES
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Register port
    input wire logic [ldoctl_pkg::ADDR_W-1:0] addr_i,
    input wire logic [ldoctl_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [ldoctl_pkg::DATA_W-1:0] rdata_o,
    // Analog status from the regulators
    input wire logic [ldoctl_pkg::NUM_LDO-1:0] pgood_i,
    // Regulator controls
    output logic [ldoctl_pkg::NUM_LDO-1:0] ldo_run_o,
    output logic [ldoctl_pkg::NUM_LDO-1:0] discharge_o,
    output logic [ldoctl_pkg::NUM_LDO-1:0] low_quiescent_mode_o,
    output logic [ldoctl_pkg::NUM_LDO-1:0][ldoctl_pkg::VCODE_W-1:0] voltage_code_o,
    // Open-drain interrupt pin
    output logic interrupt_out_n_o,
    output logic interrupt_oe_o
);

    localparam int N = ldoctl_pkg::NUM_LDO;

    // Software-visible fields
    logic [ldoctl_pkg::VCODE_W-1:0] voltage_code [0:N-1];
    logic [N-1:0] enable;
    logic [N-1:0] shutdown_discharge_enable;
    logic [N-1:0] low_quiescent_mode;
    logic [ldoctl_pkg::DELAY_W-1:0] delay_code [0:N-1];
    logic [N-1:0] fault_irq_enable;

    // Internal state
    logic [N-1:0] run;
    logic [N-1:0] fault;
    logic [N-1:0] fault_clear;
    logic [2:0] vsel_hit;
    logic [2:0] ctl_hit;
    logic [ldoctl_pkg::DATA_W-1:0] next_rdata;
    logic next_irq;

    // Address decode for both register kinds
    assign vsel_hit = ldoctl_pkg::addr_lookup(addr_i, ldoctl_pkg::VSEL_ADDR);
    assign ctl_hit = ldoctl_pkg::addr_lookup(addr_i, ldoctl_pkg::CTL_ADDR);

    // Voltage code storage; reserved bits are never stored
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            for (int i = 0; i < N; i++) begin
                voltage_code[i] <= ldoctl_pkg::VCODE_RESET;
            end
        end else if (wr_i && vsel_hit[2]) begin
            voltage_code[vsel_hit[1:0]] <= wdata_i[ldoctl_pkg::VSEL_CODE_MSB:0];
        end
    end

    // Control fields; the power-good bit is status, so writes to it are dropped
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            enable <= '0;
            shutdown_discharge_enable <= '0;
            low_quiescent_mode <= '0;
            fault_irq_enable <= '0;
            for (int i = 0; i < N; i++) begin
                delay_code[i] <= ldoctl_pkg::DELAY_RESET;
            end
        end else if (wr_i && ctl_hit[2]) begin
            enable[ctl_hit[1:0]] <= wdata_i[ldoctl_pkg::CTL_ENABLE_BIT];
            shutdown_discharge_enable[ctl_hit[1:0]] <= wdata_i[ldoctl_pkg::CTL_DISCHARGE_BIT];
            low_quiescent_mode[ctl_hit[1:0]] <= wdata_i[ldoctl_pkg::CTL_LOW_QUIESCENT_BIT];
            delay_code[ctl_hit[1:0]] <= wdata_i[ldoctl_pkg::CTL_DELAY_MSB:ldoctl_pkg::CTL_DELAY_LSB];
            fault_irq_enable[ctl_hit[1:0]] <= wdata_i[ldoctl_pkg::CTL_FAULT_IE_BIT];
        end
    end

    // Per-regulator sequencer and fault flag
    for (genvar g = 0; g < N; g++) begin : g_ldo
        // A control read acknowledges that regulator's fault
        assign fault_clear[g] = rd_i && ctl_hit[2] && (ctl_hit[1:0] == 2'(g));

        ldoctl_turnon_timer #(
            .STEP_CYCLES(TURN_ON_STEP_CYCLES)
        ) u_timer (
            .clk_i(clk_i),
            .resetn_i(resetn_i),
            .enable_i(enable[g]),
            .delay_code_i(delay_code[g]),
            .on_o(run[g])
        );

        ldoctl_fault_latch u_fault (
            .clk_i(clk_i),
            .resetn_i(resetn_i),
            .running_i(run[g]),
            .pgood_i(pgood_i[g]),
            .irq_enable_i(fault_irq_enable[g]),
            .clear_i(fault_clear[g]),
            .fault_o(fault[g])
        );

        // Field outputs come straight from the field flops
        assign low_quiescent_mode_o[g] = low_quiescent_mode[g];
        assign voltage_code_o[g] = voltage_code[g];

        a_discharge_when_off: assert property (@(posedge clk_i) disable iff (!resetn_i)
            ##1 (discharge_o[g] == ($past(shutdown_discharge_enable[g]) && !$past(run[g]))))
            else $error("discharge path does not follow shutdown state");

        a_run_follows_enable: assert property (@(posedge clk_i) disable iff (!resetn_i)
            (run[g] && !enable[g]) |=> !run[g])
            else $error("regulator kept running after disable");
    end

    // Regulator run outputs are the sequencer flops
    assign ldo_run_o = run;

    // Discharge only while shut down, including the turn-on wait
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            discharge_o <= '0;
        end else begin
            discharge_o <= shutdown_discharge_enable & ~run;
        end
    end

    // Read mux; idle cycles return zero so the data only stand after a read
    always_comb begin
        next_rdata = ldoctl_pkg::RDATA_IDLE;
        if (rd_i && vsel_hit[2]) begin
            next_rdata = {ldoctl_pkg::VSEL_RESERVED, voltage_code[vsel_hit[1:0]]};
        end else if (rd_i && ctl_hit[2]) begin
            next_rdata[ldoctl_pkg::CTL_ENABLE_BIT] = enable[ctl_hit[1:0]];
            next_rdata[ldoctl_pkg::CTL_DISCHARGE_BIT] = shutdown_discharge_enable[ctl_hit[1:0]];
            next_rdata[ldoctl_pkg::CTL_LOW_QUIESCENT_BIT] = low_quiescent_mode[ctl_hit[1:0]];
            next_rdata[ldoctl_pkg::CTL_DELAY_MSB:ldoctl_pkg::CTL_DELAY_LSB] = delay_code[ctl_hit[1:0]];
            next_rdata[ldoctl_pkg::CTL_FAULT_IE_BIT] = fault_irq_enable[ctl_hit[1:0]];
            next_rdata[ldoctl_pkg::CTL_PGOOD_BIT] = pgood_i[ctl_hit[1:0]];
        end
    end

    // Read data register
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            rdata_o <= ldoctl_pkg::RDATA_IDLE;
        end else begin
            rdata_o <= next_rdata;
        end
    end

    // Masking the enable later also hides an already latched fault
    assign next_irq = |(fault & fault_irq_enable);

    // Open-drain pin: drive low while any enabled fault is pending
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            interrupt_oe_o <= 1'b0;
            interrupt_out_n_o <= 1'b1;
        end else begin
            interrupt_oe_o <= next_irq;
            interrupt_out_n_o <= !next_irq;
        end
    end

    a_ctl_readback: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (rd_i && ctl_hit[2]) |=> (rdata_o[ldoctl_pkg::CTL_ENABLE_BIT] == $past(enable[ctl_hit[1:0]])
            && rdata_o[ldoctl_pkg::CTL_DELAY_MSB:ldoctl_pkg::CTL_DELAY_LSB] == $past(delay_code[ctl_hit[1:0]])))
        else $error("control read returned wrong enable or delay");

    a_pgood_report: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (rd_i && ctl_hit[2]) |=> (rdata_o[ldoctl_pkg::CTL_PGOOD_BIT] == $past(pgood_i[ctl_hit[1:0]])))
        else $error("power-good bit does not match the regulator");

    a_vsel_reserved: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (rd_i && vsel_hit[2]) |=> (rdata_o[ldoctl_pkg::DATA_W-1:ldoctl_pkg::VSEL_CODE_MSB+1] == ldoctl_pkg::VSEL_RESERVED
            && rdata_o[ldoctl_pkg::VSEL_CODE_MSB:0] == $past(voltage_code[vsel_hit[1:0]])))
        else $error("voltage select readback wrong");

    a_vsel_write_back: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (wr_i && vsel_hit[2]) ##1 (rd_i && addr_i == $past(addr_i))
            |=> (rdata_o[ldoctl_pkg::VSEL_CODE_MSB:0] == $past(wdata_i[ldoctl_pkg::VSEL_CODE_MSB:0], 2)))
        else $error("voltage code write not stored");

    a_quiescent_write: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (wr_i && ctl_hit[2])
            |=> (low_quiescent_mode_o[$past(ctl_hit[1:0])] == $past(wdata_i[ldoctl_pkg::CTL_LOW_QUIESCENT_BIT])))
        else $error("low quiescent mode output did not take the write");

    a_unmapped_zero: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (!(rd_i && (vsel_hit[2] || ctl_hit[2]))) |=> (rdata_o == ldoctl_pkg::RDATA_IDLE))
        else $error("read data not idle after unmapped or no read");

    a_irq_masked: assert property (@(posedge clk_i) disable iff (!resetn_i)
        ((fault & fault_irq_enable) == '0) |=> (interrupt_out_n_o && !interrupt_oe_o))
        else $error("interrupt driven with no enabled fault");

    a_irq_on_fault: assert property (@(posedge clk_i) disable iff (!resetn_i)
        ((fault & fault_irq_enable) != '0) |=> (!interrupt_out_n_o && interrupt_oe_o))
        else $error("enabled fault did not pull the interrupt");

endmodule : ldoctl_regs

// ---- hw/ldoctl_turnon_timer.sv ----
// Purpose: Per-regulator turn-on sequencer that waits a coded delay after enable
// Assumes: delay_code_i may change at any time; the new value applies at once
// Notes: Disable is immediate, there is no turn-off delay

`timescale 1ns/1ps

module ldoctl_turnon_timer #(
    parameter int STEP_CYCLES = ldoctl_pkg::DELAY_STEP_CYCLES
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Control
    input wire logic enable_i,
    input wire logic [ldoctl_pkg::DELAY_W-1:0] delay_code_i,
    // Regulator run request
    output logic on_o
);

    ldoctl_pkg::ldoctl_state_e state;
    ldoctl_pkg::ldoctl_state_e next_state;
    logic [ldoctl_pkg::DELAY_CNT_W-1:0] count;
    logic [ldoctl_pkg::DELAY_CNT_W-1:0] target;

    // Wait length is code times one step
    assign target = ldoctl_pkg::DELAY_CNT_W'(ldoctl_pkg::DELAY_CNT_W'(delay_code_i)
                    * ldoctl_pkg::DELAY_CNT_W'(STEP_CYCLES));

    // Next state; enable low always wins so shutdown never waits
    always_comb begin
        next_state = state;
        case (state)
            ldoctl_pkg::LDOCTL_OFF: begin
                if (enable_i) begin
                    next_state = ldoctl_pkg::LDOCTL_WAIT;
                end
            end
            ldoctl_pkg::LDOCTL_WAIT: begin
                if (!enable_i) begin
                    next_state = ldoctl_pkg::LDOCTL_OFF;
                end else if (count >= target) begin
                    next_state = ldoctl_pkg::LDOCTL_ON;
                end
            end
            ldoctl_pkg::LDOCTL_ON: begin
                if (!enable_i) begin
                    next_state = ldoctl_pkg::LDOCTL_OFF;
                end
            end
            default: begin
                next_state = ldoctl_pkg::LDOCTL_OFF;
            end
        endcase
    end

    // State and registered run output
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            state <= ldoctl_pkg::LDOCTL_OFF;
            on_o <= 1'b0;
        end else begin
            state <= next_state;
            on_o <= (next_state == ldoctl_pkg::LDOCTL_ON);
        end
    end

    // Wait counter, restarts on every entry to the wait state
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            count <= '0;
        end else if (state != ldoctl_pkg::LDOCTL_WAIT) begin
            count <= '0;
        end else if (count < target) begin
            count <= count + 1'b1;
        end
    end

    a_on_needs_enable: assert property (@(posedge clk_i) disable iff (!resetn_i)
        on_o |-> $past(enable_i))
        else $error("regulator running without enable");

    a_delay_not_done: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (state == ldoctl_pkg::LDOCTL_WAIT && count < target) |=> !on_o)
        else $error("regulator turned on before its delay ran out");

endmodule : ldoctl_turnon_timer
